// >>> alu_flags.sv
// Purpose: Combinational ALU with condition flag generation.
// Assumes: Carry input comes from the status register.
// Notes: The mask marks the flags an operation is allowed to change.
`timescale 1ns/10ps
`default_nettype none
module alu_flags (
    // Operation
    input wire ida_pkg::alu_op_e op_i,
    input wire ida_pkg::byte_t a_i,
    input wire ida_pkg::byte_t b_i,
    input wire logic carry_i,
    // Result
    output var ida_pkg::byte_t result_o,
    output var ida_pkg::flags_s flags_o,
    output var ida_pkg::flags_s mask_o
);
    import ida_pkg::*;

    logic [8:0] sum;
    logic [4:0] low;
    byte_t opb;

    // Subtraction adds the two's complement, so carries read as inverted borrow.
    always_comb begin
        opb = (op_i == OP_SUB) ? ~b_i : b_i;
        sum = {1'b0, a_i} + {1'b0, opb} + {8'h00, op_i == OP_SUB};
        low = {1'b0, a_i[3:0]} + {1'b0, opb[3:0]} + {4'h0, op_i == OP_SUB};
    end

    always_comb begin
        result_o = sum[7:0];
        flags_o = '0;
        mask_o = '0;
        mask_o.n = 1'b1;
        mask_o.z = 1'b1;
        case (op_i)
            OP_ADD, OP_SUB: begin
                mask_o = '1;
                flags_o.c = sum[8];
                flags_o.dc = low[4];
                flags_o.ov = (a_i[7] == opb[7]) && (sum[7] != a_i[7]);
            end
            OP_AND: result_o = a_i & b_i;
            OP_IOR: result_o = a_i | b_i;
            OP_XOR: result_o = a_i ^ b_i;
            OP_RLC: begin
                result_o = {a_i[6:0], carry_i};
                mask_o.c = 1'b1;
                mask_o.dc = 1'b1;
                flags_o.c = a_i[7];
                flags_o.dc = a_i[3];
            end
            OP_RRC: begin
                result_o = {carry_i, a_i[7:1]};
                mask_o.c = 1'b1;
                mask_o.dc = 1'b1;
                flags_o.c = a_i[0];
                flags_o.dc = a_i[4];
            end
            default: begin
                result_o = a_i;
                mask_o = '0;
            end
        endcase
        flags_o.n = result_o[7];
        flags_o.z = (result_o == 8'h00);
    end
endmodule : alu_flags
`default_nettype wire

// >>> data_ram_model.sv
// Purpose: Synchronous data RAM standing behind the addressing unit.
// Assumes: Read data appears after the edge that sees the read strobe.
// Notes: The bench preloads and inspects mem directly.
`timescale 1ns/10ps
`default_nettype none
module data_ram_model (
    // Clock
    input wire logic clk_i,
    // Access port
    input wire ida_pkg::addr_t addr_i,
    input wire logic re_i,
    input wire logic we_i,
    input wire ida_pkg::byte_t wdata_i,
    output var ida_pkg::byte_t rdata_o
);
    import ida_pkg::*;
    // ========================================================
    // Storage
    byte_t mem [4096];
    // Read data holds one cycle only; it is then scrambled so a late sample is caught.
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        if (re_i) begin
            rdata_o <= mem[addr_i];
        end else begin
            rdata_o <= ~rdata_o;
        end
    end
endmodule : data_ram_model
`default_nettype wire

// >>> ida_pkg.sv
// Purpose: Shared types and constants of the indirect data addressing unit.
// Assumes: A 12-bit data space of 8-bit bytes and three data pointers.
// Notes: Wishbone offsets are byte addresses of 32-bit words.
`default_nettype none
package ida_pkg;
    typedef logic [11:0] addr_t;
    typedef logic [7:0] byte_t;
    localparam int NUM_PTR = 3;
    localparam addr_t ADDR_ONE = 12'h001;
    // ========================================================
    // Data-space map of pointer bytes and virtual locations
    localparam addr_t PREG_BASE = 12'hFF8;
    localparam addr_t PREG_LAST = 12'hFFD;
    localparam addr_t VLOC_BASE = 12'hFE0;
    localparam addr_t VLOC_LAST = 12'hFF7;
    localparam logic [2:0] VLOC_MAX_SUB = 3'h4;
    localparam logic [3:0] PHI_ZERO = 4'h0;
    typedef enum logic [2:0] {
        MODE_PLAIN = 3'h0,
        MODE_POST_DEC = 3'h1,
        MODE_POST_INC = 3'h2,
        MODE_PRE_INC = 3'h3,
        MODE_OFFSET = 3'h4
    } mode_e;
    // ========================================================
    // ALU operations and status layout
    typedef enum logic [2:0] {
        OP_ADD = 3'h0,
        OP_SUB = 3'h1,
        OP_AND = 3'h2,
        OP_IOR = 3'h3,
        OP_XOR = 3'h4,
        OP_RLC = 3'h5,
        OP_RRC = 3'h6,
        OP_MOV = 3'h7
    } alu_op_e;
    localparam int ST_Z = 2;
    localparam int ST_N = 4;
    localparam byte_t ST_RESET = 8'h00;
    // ========================================================
    // Wishbone register offsets
    localparam logic [7:0] WB_PTR_LAST = 8'h14;
    localparam logic [7:0] WB_WORKING_REGISTER = 8'h18;
    localparam logic [7:0] WB_STATUS = 8'h1C;
    localparam logic [7:0] WB_STATE = 8'h20;
    // ========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [1:0] ptr;
        mode_e mode;
        logic we;
        byte_t wdata;
    } ind_req_s;
    typedef struct packed {
        logic valid;
        alu_op_e op;
        byte_t a;
        byte_t b;
        logic dest_status;
    } alu_req_s;
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } flags_s;
endpackage : ida_pkg
`default_nettype wire

// >>> indirect_data_addressing.sv
// Purpose: Indirect data-memory addressing through three data pointers,
//          with the ALU condition flag register.
// Assumes: Synchronous data RAM with one cycle of read latency.
// Notes: One indirect access is in flight at a time.
// Functional notes
// - Three 12-bit pointers, each a high and low byte, span 4096 bytes.
// - A virtual location operand accesses memory at the pointer's address.
// - Reading a virtual location indirectly returns zero and sets zero flag.
// - Writing a virtual location indirectly does nothing, flags untouched.
// - Five locations per pointer: plain, post-dec, post-inc, pre-inc, offset.
// - Offset mode adds sign-extended working register; neither operand changes.
// - Pointer increments and decrements never touch status flags.
// - Indirect write to a pointer byte stores it and cancels pointer update.
// - Flag-updating results into status keep written data off the flags.
// - Negative flag, bit 4, copies the result's top bit.
// - Overflow flag, bit 3, marks signed overflow flipping bit 7.
// - Zero flag, bit 2, is set exactly when the result is zero.
// - Digit carry, bit 1, is nibble carry, inverted borrow; rotates load bit 4/3.
// - Carry, bit 0, is top-bit carry, inverted borrow; rotates load an end bit.
// - Subtraction adds the two's complement of the second operand.
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module indirect_data_addressing (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core indirect access
    input wire ida_pkg::ind_req_s ind_req_i,
    output logic ind_ready_o,
    output logic ind_done_o,
    output ida_pkg::byte_t ind_rdata_o,
    // Core ALU
    input wire ida_pkg::alu_req_s alu_req_i,
    output ida_pkg::byte_t alu_result_o,
    output ida_pkg::byte_t status_o,
    // Data RAM
    output ida_pkg::addr_t ram_addr_o,
    output logic ram_re_o,
    output logic ram_we_o,
    output ida_pkg::byte_t ram_wdata_o,
    input wire ida_pkg::byte_t ram_rdata_i
);
    import ida_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_ISSUE = 4'h2,
        S_WAIT = 4'h4,
        S_RESP = 4'h8
    } state_e;

    state_e state;
    addr_t ptr [NUM_PTR];
    byte_t working_register;
    byte_t status;
    logic last_trap;
    logic wb_wr;
    logic accept;
    addr_t cur;
    addr_t acc_addr;
    addr_t next_ptr;
    logic trap;
    logic hit_preg;
    logic [1:0] hit_idx;
    logic hit_high;
    logic ptr_mod;
    byte_t preg_val;
    byte_t alu_res;
    flags_s alu_flg;
    flags_s alu_msk;

    // ========================================================
    // Wishbone slave
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Unmapped offsets still acknowledge and read as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else begin
            wb_dat_o <= '0;
            if (wb_adr_i <= WB_PTR_LAST) begin
                wb_dat_o[7:0] <= wb_adr_i[2] ? {PHI_ZERO, ptr[wb_adr_i[4:3]][11:8]}
                                             : ptr[wb_adr_i[4:3]][7:0];
            end else if (wb_adr_i == WB_WORKING_REGISTER) begin
                wb_dat_o[7:0] <= working_register;
            end else if (wb_adr_i == WB_STATUS) begin
                wb_dat_o[7:0] <= status;
            end else if (wb_adr_i == WB_STATE) begin
                wb_dat_o[1:0] <= {state != S_IDLE, last_trap};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            working_register <= 8'h00;
        end else if (wb_wr && wb_adr_i == WB_WORKING_REGISTER) begin
            working_register <= wb_dat_i[7:0];
        end
    end

    // ========================================================
    // Address formation for an accepted request
    assign ind_ready_o = (state == S_IDLE);
    assign accept = ind_ready_o && ind_req_i.valid;
    assign cur = ptr[ind_req_i.ptr];

    always_comb begin
        case (ind_req_i.mode)
            MODE_PRE_INC: acc_addr = cur + ADDR_ONE;
            MODE_OFFSET: acc_addr = cur + {{4{working_register[7]}}, working_register};
            default: acc_addr = cur;
        endcase
        case (ind_req_i.mode)
            MODE_POST_DEC: next_ptr = cur - ADDR_ONE;
            MODE_POST_INC, MODE_PRE_INC: next_ptr = cur + ADDR_ONE;
            default: next_ptr = cur;
        endcase
    end

    assign trap = (acc_addr >= VLOC_BASE) && (acc_addr <= VLOC_LAST)
                  && (acc_addr[2:0] <= VLOC_MAX_SUB);
    assign hit_preg = (acc_addr >= PREG_BASE) && (acc_addr <= PREG_LAST);
    assign hit_idx = acc_addr[2:1] - PREG_BASE[2:1];
    assign hit_high = acc_addr[0];
    assign preg_val = hit_high ? {PHI_ZERO, ptr[hit_idx][11:8]} : ptr[hit_idx][7:0];
    // A trapped write is a no-op, so its pointer is left alone as well.
    assign ptr_mod = accept && (next_ptr != cur)
                     && !(ind_req_i.we && (hit_preg || trap));

    // ========================================================
    // Pointer registers; a bus write lands after core updates and wins.
    for (genvar p = 0; p < NUM_PTR; p++) begin : g_ptr
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ptr[p] <= '0;
            end else begin
                if (ptr_mod && ind_req_i.ptr == 2'(p)) begin
                    ptr[p] <= next_ptr;
                end
                if (accept && ind_req_i.we && hit_preg && !trap && hit_idx == 2'(p)) begin
                    if (hit_high) begin
                        ptr[p][11:8] <= ind_req_i.wdata[3:0];
                    end else begin
                        ptr[p][7:0] <= ind_req_i.wdata;
                    end
                end
                if (wb_wr && wb_adr_i <= WB_PTR_LAST && wb_adr_i[4:3] == 2'(p)) begin
                    if (wb_adr_i[2]) begin
                        ptr[p][11:8] <= wb_dat_i[3:0];
                    end else begin
                        ptr[p][7:0] <= wb_dat_i[7:0];
                    end
                end
            end
        end
    end

    // ========================================================
    // Access sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    if (accept) begin
                        state <= (trap || hit_preg) ? S_RESP : S_ISSUE;
                    end
                end
                S_ISSUE: state <= ram_re_o ? S_WAIT : S_RESP;
                S_WAIT: state <= S_RESP;
                S_RESP: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ram_addr_o <= '0;
            ram_re_o <= 1'b0;
            ram_we_o <= 1'b0;
            ram_wdata_o <= 8'h00;
        end else begin
            ram_re_o <= 1'b0;
            ram_we_o <= 1'b0;
            if (accept && !trap && !hit_preg) begin
                ram_addr_o <= acc_addr;
                ram_re_o <= !ind_req_i.we;
                ram_we_o <= ind_req_i.we;
                ram_wdata_o <= ind_req_i.wdata;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ind_rdata_o <= 8'h00;
            last_trap <= 1'b0;
        end else begin
            if (accept) begin
                last_trap <= trap;
                ind_rdata_o <= (trap || ind_req_i.we) ? 8'h00 : preg_val;
            end
            if (state == S_WAIT) begin
                ind_rdata_o <= ram_rdata_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ind_done_o <= 1'b0;
        end else begin
            ind_done_o <= (state != S_RESP) && (next_state_resp());
        end
    end

    function automatic logic next_state_resp();
        next_state_resp = (state == S_WAIT) || (state == S_ISSUE && !ram_re_o)
                          || (accept && (trap || hit_preg));
    endfunction : next_state_resp

    // ========================================================
    // ALU and condition flags
    alu_flags u_alu (
        .op_i(alu_req_i.op),
        .a_i(alu_req_i.a),
        .b_i(alu_req_i.b),
        .carry_i(status[0]),
        .result_o(alu_res),
        .flags_o(alu_flg),
        .mask_o(alu_msk)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alu_result_o <= 8'h00;
        end else if (alu_req_i.valid) begin
            alu_result_o <= alu_res;
        end
    end

    // Later assignments win: bus write, then ALU, then the trap's zero flag.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= ST_RESET;
        end else begin
            if (wb_wr && wb_adr_i == WB_STATUS) begin
                status[4:0] <= wb_dat_i[4:0];
            end
            if (alu_req_i.valid) begin
                for (int b = 0; b < 5; b++) begin
                    if (alu_msk[b]) begin
                        status[b] <= alu_flg[b];
                    end else if (alu_req_i.dest_status) begin
                        status[b] <= alu_res[b];
                    end
                end
            end
            if (accept && trap && !ind_req_i.we) begin
                status[ST_Z] <= 1'b1;
            end
        end
    end

    assign status_o = status;

    // ========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [1:0] idx_q;
    addr_t nxt_q;
    always_ff @(posedge clk_i) begin
        idx_q <= ind_req_i.ptr;
        nxt_q <= next_ptr;
    end

    sequence s_ram_read;
        ram_re_o ##1 !ram_re_o ##1 ind_done_o;
    endsequence

    sequence s_quiet_cycle;
        !wb_wr && !alu_req_i.valid;
    endsequence

    trap_read_zero_a: assert property (
        accept && trap && !ind_req_i.we && !alu_req_i.valid
        |=> ind_done_o && ind_rdata_o == 8'h00 && status[ST_Z])
        else $error("trapped read did not return zero with zero flag");

    trap_write_nop_a: assert property (
        ((accept && trap && ind_req_i.we) and s_quiet_cycle)
        |=> $stable(status) && !ram_we_o && ptr[idx_q] == $past(cur))
        else $error("trapped write changed state");

    ram_read_path_a: assert property (
        accept && !trap && !hit_preg && !ind_req_i.we
        |=> s_ram_read ##0 ind_rdata_o == $past(ram_rdata_i))
        else $error("indirect read did not return ram data");

    offset_addr_a: assert property (
        accept && ind_req_i.mode == MODE_OFFSET && !trap && !hit_preg
        |=> ram_addr_o == $past(acc_addr) && ptr[idx_q] == $past(cur))
        else $error("offset access formed wrong address");

    ptr_step_a: assert property (
        ptr_mod && !wb_wr |=> ptr[idx_q] == nxt_q)
        else $error("pointer step wrong");

    ptr_write_hold_a: assert property (
        accept && ind_req_i.we && hit_preg |-> !ptr_mod ##1 !ram_we_o)
        else $error("pointer byte write still stepped pointer");

    step_no_flags_a: assert property (
        ((accept && !trap) and s_quiet_cycle) |=> $stable(status))
        else $error("pointer step altered status");

    status_mask_a: assert property (
        alu_req_i.valid && alu_req_i.dest_status && !(accept && trap)
        |=> ((status[4:0] ^ $past(alu_flg)) & $past(alu_msk)) == 5'h00)
        else $error("status write reached updated flags");

    flag_value_a: assert property (
        alu_req_i.valid && alu_msk.z && !(accept && trap)
        |=> status[ST_Z] == ($past(alu_res) == 8'h00) && status[ST_N] == $past(alu_res[7]))
        else $error("zero or negative flag wrong");

    status_upper_a: assert property (
        status[7:5] == 3'h0)
        else $error("unimplemented status bits set");
endmodule : indirect_data_addressing
`default_nettype wire

// >>> indirect_data_addressing_bench.sv
// Purpose: Self-checking bench of the indirect data addressing unit.
// Assumes: Wishbone answers are awaited, never counted in advance.
// Notes: Ordinary cases run from tables; reset and traps are hand-written.
`timescale 1ns/10ps
`default_nettype none
module indirect_data_addressing_bench;
    import ida_pkg::*;
    typedef struct packed {
        logic [1:0] p;
        mode_e m;
        logic w;
        byte_t wr;
        addr_t st;
        addr_t ea;
        addr_t ef;
    } irow_s;
    typedef struct packed {
        alu_op_e op;
        byte_t a;
        byte_t b;
        byte_t s0;
        logic d;
        byte_t res;
        byte_t st;
    } arow_s;
    localparam irow_s IROWS [8] = '{
        '{2'h0, MODE_PLAIN, 1'b1, 8'h00, 12'h100, 12'h100, 12'h100},
        '{2'h1, MODE_POST_DEC, 1'b0, 8'h00, 12'h200, 12'h200, 12'h1FF},
        '{2'h2, MODE_POST_INC, 1'b1, 8'h00, 12'h0FF, 12'h0FF, 12'h100},
        '{2'h0, MODE_PRE_INC, 1'b0, 8'h00, 12'hFFF, 12'h000, 12'h000},
        '{2'h1, MODE_POST_DEC, 1'b1, 8'h00, 12'h000, 12'h000, 12'hFFF},
        '{2'h2, MODE_OFFSET, 1'b0, 8'h80, 12'h300, 12'h280, 12'h300},
        '{2'h0, MODE_OFFSET, 1'b1, 8'h7F, 12'h300, 12'h37F, 12'h300},
        '{2'h1, MODE_PRE_INC, 1'b1, 8'h00, 12'h2FF, 12'h300, 12'h300}};
    localparam arow_s AROWS [12] = '{
        '{OP_ADD, 8'h7F, 8'h01, 8'h00, 1'b0, 8'h80, 8'h1A},
        '{OP_ADD, 8'hFF, 8'h01, 8'h00, 1'b0, 8'h00, 8'h07},
        '{OP_SUB, 8'h05, 8'h05, 8'h00, 1'b0, 8'h00, 8'h07},
        '{OP_SUB, 8'h00, 8'h01, 8'h00, 1'b0, 8'hFF, 8'h10},
        '{OP_SUB, 8'h80, 8'h01, 8'h00, 1'b0, 8'h7F, 8'h09},
        '{OP_AND, 8'hF0, 8'h0F, 8'h00, 1'b0, 8'h00, 8'h04},
        '{OP_XOR, 8'h80, 8'h00, 8'h00, 1'b0, 8'h80, 8'h10},
        '{OP_RLC, 8'h88, 8'h00, 8'h01, 1'b0, 8'h11, 8'h03},
        '{OP_RRC, 8'h11, 8'h00, 8'h00, 1'b0, 8'h08, 8'h03},
        '{OP_MOV, 8'h00, 8'h00, 8'h1B, 1'b0, 8'h00, 8'h1B},
        '{OP_IOR, 8'h80, 8'h01, 8'h01, 1'b0, 8'h81, 8'h11},
        '{OP_XOR, 8'h14, 8'h00, 8'h00, 1'b1, 8'h14, 8'h00}};
    // ========================================================
    // Stimulus and design
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat = 32'h0000_0000;
    ind_req_s ind_req = '0;
    alu_req_s alu_req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, ind_ready_o, ind_done_o, ram_re_o, ram_we_o;
    byte_t ind_rdata_o, alu_result_o, status_o, ram_wdata_o, ram_rdata_i, q, d, junk;
    addr_t ram_addr_o, a;
    irow_s r;
    arow_s s;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    indirect_data_addressing DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ind_req_i(ind_req),
        .ind_ready_o(ind_ready_o), .ind_done_o(ind_done_o), .ind_rdata_o(ind_rdata_o),
        .alu_req_i(alu_req), .alu_result_o(alu_result_o), .status_o(status_o),
        .ram_addr_o(ram_addr_o), .ram_re_o(ram_re_o), .ram_we_o(ram_we_o),
        .ram_wdata_o(ram_wdata_o), .ram_rdata_i(ram_rdata_i));
    data_ram_model ram (.clk_i(clk_i), .addr_i(ram_addr_o), .re_i(ram_re_o),
        .we_i(ram_we_o), .wdata_i(ram_wdata_o), .rdata_o(ram_rdata_i));
    initial begin
        forever begin
            #10 clk_i = ~clk_i;
        end
    end
    // ========================================================
    // Tasks
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic chk(input addr_t got, input addr_t exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] ad, input byte_t dt, output byte_t rq);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= ad;
        wb_dat <= {24'h00_0000, dt};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        rq = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (k >= 50) begin
            failures++;
        end
    endtask : wb
    task automatic ind(input logic [1:0] p, input mode_e m, input logic w, input byte_t dt,
                       output byte_t rq);
        int k;
        k = 0;
        @(posedge clk_i);
        ind_req <= '{1'b1, p, m, w, dt};
        do begin
            @(posedge clk_i);
            k++;
        end while (ind_ready_o !== 1'b1 && k < 50);
        ind_req.valid <= 1'b0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ind_done_o !== 1'b1 && k < 50);
        rq = ind_rdata_o;
        if (k >= 50) begin
            failures++;
        end
    endtask : ind
    task automatic set_ptr(input logic [1:0] p, input addr_t v);
        wb(1'b1, {3'h0, p, 3'h0}, v[7:0], junk);
        wb(1'b1, {3'h0, p, 3'h4}, {4'h0, v[11:8]}, junk);
    endtask : set_ptr
    task automatic get_ptr(input logic [1:0] p, output addr_t v);
        byte_t lo;
        byte_t hi;
        wb(1'b0, {3'h0, p, 3'h0}, 8'h00, lo);
        wb(1'b0, {3'h0, p, 3'h4}, 8'h00, hi);
        v = {hi[3:0], lo};
    endtask : get_ptr
    // ========================================================
    // Timeout: the whole sequence needs well under two thousand cycles.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end
    // ========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            wb(1'b0, 8'(4 * i), 8'h00, q);
            chk(q, 12'h000);
        end
        wb(1'b1, 8'h40, 8'hFF, junk);
        wb(1'b0, 8'h40, 8'h00, q);
        chk(q, 12'h000);
        wb_sel <= 4'h0;
        wb(1'b1, WB_WORKING_REGISTER, 8'h55, junk);
        wb_sel <= 4'hF;
        wb(1'b0, WB_WORKING_REGISTER, 8'h00, q);
        chk(q, 12'h000);
        foreach (IROWS[i]) begin
            r = IROWS[i];
            set_ptr(r.p, r.st);
            wb(1'b1, WB_WORKING_REGISTER, r.wr, junk);
            wb(1'b1, WB_STATUS, 8'h00, junk);
            d = 8'hA0 + 8'(i);
            ram.mem[r.ea] = d;
            if (r.w) begin
                ram.mem[r.ea] = ~d;
            end
            ind(r.p, r.m, r.w, d, q);
            chk(r.w ? ram.mem[r.ea] : q, d);
            get_ptr(r.p, a);
            chk(a, r.ef);
            wb(1'b0, WB_WORKING_REGISTER, 8'h00, q);
            chk(q, r.wr);
            chk(status_o, 12'h000);
        end
        foreach (AROWS[i]) begin
            s = AROWS[i];
            wb(1'b1, WB_STATUS, s.s0, junk);
            @(posedge clk_i);
            alu_req <= '{1'b1, s.op, s.a, s.b, s.d};
            @(posedge clk_i);
            alu_req.valid <= 1'b0;
            @(posedge clk_i);
            chk(alu_result_o, s.res);
            chk(status_o, s.st);
        end
        // A plain read first leaves non-zero read data, so the trap must clear it.
        set_ptr(2'h0, 12'h100);
        ind(2'h0, MODE_PLAIN, 1'b0, 8'h00, q);
        chk(q, 12'h0A0);
        // A pointer aimed at a virtual location traps both directions.
        set_ptr(2'h0, 12'hFE8);
        ram.mem[12'hFE8] = 8'h5A;
        wb(1'b1, WB_STATUS, 8'h00, junk);
        ind(2'h0, MODE_PLAIN, 1'b0, 8'h00, q);
        chk(q, 12'h000);
        chk(status_o, 12'h004);
        wb(1'b0, WB_STATE, 8'h00, q);
        chk(q, 12'h001);
        set_ptr(2'h2, 12'hFF2);
        ram.mem[12'hFF2] = 8'h66;
        wb(1'b1, WB_STATUS, 8'h15, junk);
        ind(2'h2, MODE_POST_INC, 1'b1, 8'h99, q);
        chk(ram.mem[12'hFF2], 12'h066);
        chk(status_o, 12'h015);
        get_ptr(2'h2, a);
        chk(a, 12'hFF2);
        // Indirect access to pointer bytes themselves.
        set_ptr(2'h0, 12'hFF8);
        ind(2'h0, MODE_POST_INC, 1'b1, 8'h34, q);
        get_ptr(2'h0, a);
        chk(a, 12'hF34);
        set_ptr(2'h2, 12'h5A3);
        set_ptr(2'h1, 12'hFFD);
        ind(2'h1, MODE_PLAIN, 1'b0, 8'h00, q);
        chk(q, 12'h005);
        // A reset in mid-run clears pointers and status again.
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        get_ptr(2'h2, a);
        chk(a, 12'h000);
        chk(status_o, 12'h000);
        test_done();
    end
endmodule : indirect_data_addressing_bench
`default_nettype wire
